// ### pkg/preload_pkg.sv
// ****************************************************************
// Shared constants of the register preload chain
// ****************************************************************
package preload_pkg;

  // Number of output macrocells that may sit in the chain
  localparam int unsigned NUM_CELLS   = 8;

  // Value of every macrocell register after reset
  localparam logic [7:0]  STATE_RESET = 8'h00;

  // Value of a single cell register after reset
  localparam logic        CELL_RESET  = 1'h0;

  // Index of the bottom macrocell, where the chain fills from when that cell is registered
  localparam int unsigned BOTTOM_CELL = 0;

  // Macrocell register source selection
  typedef enum logic [1:0] {
    CELL_HOLD,
    CELL_SHIFT,
    CELL_NEXT
  } cell_op_t;

endpackage : preload_pkg

// ### design/macro_cell.sv
`timescale 1ns/1ps
// ****************************************************************
// One output macrocell register with preload and normal load paths
// ****************************************************************
module macro_cell (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Source selection and data
  input  wire preload_pkg::cell_op_t op,
  input  wire logic                 shift_d,
  input  wire logic                 next_d,
  // Register output
  output logic                      q
);
  import preload_pkg::*;

  logic q_next;  // Value taken at the next enabled edge

  // Select the source; shift forces any level, legal or not
  always_comb begin
    unique case (op)
      CELL_SHIFT: q_next = shift_d;
      CELL_NEXT:  q_next = next_d;
      default:    q_next = q;  // Hold, also covers the unused code
    endcase
  end

  // Register itself, frozen while the enable is low
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= CELL_RESET;
    end else if (ce) begin
      q <= q_next;
    end
  end

endmodule : macro_cell

// ### design/register_preload_chain.sv
`timescale 1ns/1ps
// Overview of operation
// - Preload mode only while pin at supervoltage
// - Each shift clock rise shifts one bit
// - Only registered macrocells form the chain
// - Chain fills from bottom register upward
// - Any register forced high or low synchronously
// - Normal clock loads next state after preload
module register_preload_chain (
  // Clock, reset and freeze
  input  wire  logic                              CLK,
  input  wire  logic                              RST,
  input  wire  logic                              CE,
  // Preload control pin, high while held at the supervoltage
  input  wire  logic                              PRELOAD_CONTROL_PIN,
  // Serial preload path
  input  wire  logic                              PRELOAD_SHIFT_CLOCK,
  input  wire  logic                              SERIAL_PRELOAD_IN,
  output logic                                    SERIAL_PRELOAD_OUT,
  output logic                                    SERIAL_PRELOAD_OUT_OE,
  // Macrocell configuration: bit set means registered output
  input  wire  logic [preload_pkg::NUM_CELLS-1:0] REGISTERED_MODE,
  // Normal operation: state clock and next state from the array
  input  wire  logic                              STATE_CLOCK,
  input  wire  logic [preload_pkg::NUM_CELLS-1:0] NEXT_STATE,
  // Macrocell register outputs
  output logic [preload_pkg::NUM_CELLS-1:0]       STATE_Q
);
  import preload_pkg::*;

  // ****************************************************************
  // Chain helpers
  // ****************************************************************

  // Source of cell i: nearest registered cell below, else serial in
  function automatic logic chain_src(input logic [NUM_CELLS-1:0] mode,
                                     input logic [NUM_CELLS-1:0] q,
                                     input logic                 sin,
                                     input int unsigned          i);
    logic found;
    logic v;
    // Start from the serial input; any registered cell below i replaces it
    found = 1'b0;
    v     = sin;
    for (int unsigned j = 0; j < NUM_CELLS; j++) begin
      if (j < i && mode[j]) begin
        v     = q[j];
        found = 1'b1;
      end
    end
    // Later hits overwrite earlier ones, so v ends as the nearest cell below
    return found ? v : sin;
  endfunction : chain_src

  // Bit at the far (top) end of the chain
  function automatic logic chain_top(input logic [NUM_CELLS-1:0] mode,
                                     input logic [NUM_CELLS-1:0] q);
    logic v;
    v = 1'b1;  // Open-drain idles released when no cell is registered
    // The last registered cell met walking upward is the far end
    for (int unsigned j = 0; j < NUM_CELLS; j++) begin
      if (mode[j]) begin
        v = q[j];
      end
    end
    return v;
  endfunction : chain_top

  // ****************************************************************
  // Edge detection and mode decode
  // ****************************************************************

  // The shift and state clocks are sampled, not used as clocks: each pulse
  // must stand at least one CLK cycle high and one low, or an edge is lost
  logic                 shift_prev_reg;  // Last shift clock sample
  logic                 clock_prev_reg;  // Last state clock sample
  logic                 out_reg;         // Serial out level register
  logic                 out_oe_reg;      // Serial out pull-down enable
  logic                 out_oe_next;     // Its next value
  logic [NUM_CELLS-1:0] src_vec;         // Shift source of each cell
  logic [NUM_CELLS-1:0] q;               // Macrocell register values
  cell_op_t             op_vec [NUM_CELLS];  // Per-cell operation

  // Decoded strobes, acted on only in cycles where CE is high
  wire preload_on = PRELOAD_CONTROL_PIN;
  wire shift_now  = PRELOAD_SHIFT_CLOCK & ~shift_prev_reg;
  wire clock_now  = STATE_CLOCK & ~clock_prev_reg;
  wire top_bit    = chain_top(REGISTERED_MODE, q);

  // A one is left to the pull-up, so an idle tester sees the line high
  // Pull the line low only for a zero while the output buffer is on
  assign out_oe_next = preload_on & ~top_bit;

  // ****************************************************************
  // Macrocells
  // ****************************************************************

  // Preload wins over the state clock, so a shift never races a load
  // A cell left out of the chain keeps its value through shifts and clocks
  generate
    for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
      assign src_vec[i] = chain_src(REGISTERED_MODE, q, SERIAL_PRELOAD_IN, i);
      // Combinational cells are skipped by the shift path
      assign op_vec[i] = !REGISTERED_MODE[i]         ? CELL_HOLD :
                         (preload_on && shift_now)   ? CELL_SHIFT :
                         (!preload_on && clock_now)  ? CELL_NEXT :
                                                       CELL_HOLD;
      // Each cell flop sits in its own instance so the chain order stays visible
      macro_cell u_cell (
        .clk     (CLK),
        .rst     (RST),
        .ce      (CE),
        .op      (op_vec[i]),
        .shift_d (src_vec[i]),
        .next_d  (NEXT_STATE[i]),
        .q       (q[i])
      );
    end
  endgenerate

  // Every output comes straight from a flop: cell registers and serial pair
  assign STATE_Q               = q;
  assign SERIAL_PRELOAD_OUT    = out_reg;
  assign SERIAL_PRELOAD_OUT_OE = out_oe_reg;

  // ****************************************************************
  // Edge samplers and serial output register
  // ****************************************************************

  // Serial out lags the chain top by one cycle; tester samples late
  always_ff @(posedge CLK) begin
    if (RST) begin
      // Samplers clear, so a clock pin already high at release is an edge
      shift_prev_reg <= 1'b0;
      clock_prev_reg <= 1'b0;
      out_reg        <= 1'b0;
      out_oe_reg     <= 1'b0;
    end else if (CE) begin
      // Everything here freezes with CE, the edge samplers too
      shift_prev_reg <= PRELOAD_SHIFT_CLOCK;
      clock_prev_reg <= STATE_CLOCK;
      out_reg        <= 1'b0;         // Open-drain: only ever pulls low
      out_oe_reg     <= out_oe_next;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************

  // One accepted shift edge and one accepted state clock edge
  sequence s_shift;
    CE && preload_on && shift_now;
  endsequence

  sequence s_next;
    CE && !preload_on && clock_now;
  endsequence

  a_mode_out_off: assert property (@(posedge CLK) disable iff (RST)
    CE && !preload_on |=> !SERIAL_PRELOAD_OUT_OE)
    else $error("serial out driven outside preload mode");

  a_shift_chain_load: assert property (@(posedge CLK) disable iff (RST)
    s_shift |=> (q & $past(REGISTERED_MODE)) == ($past(src_vec) & $past(REGISTERED_MODE)))
    else $error("shift edge did not move chain by one");

  a_comb_cells_skip: assert property (@(posedge CLK) disable iff (RST)
    s_shift |=> (q & ~$past(REGISTERED_MODE)) == ($past(q) & ~$past(REGISTERED_MODE)))
    else $error("combinational cell changed during shift");

  a_bottom_fill: assert property (@(posedge CLK) disable iff (RST)
    s_shift and REGISTERED_MODE[BOTTOM_CELL]
      |=> q[BOTTOM_CELL] == $past(SERIAL_PRELOAD_IN))
    else $error("bottom cell did not take serial input");

  a_force_hold: assert property (@(posedge CLK) disable iff (RST)
    !(CE && (shift_now || clock_now)) |=> $stable(q))
    else $error("register changed without an enabled edge");

  a_next_state: assert property (@(posedge CLK) disable iff (RST)
    s_next |=> (q & $past(REGISTERED_MODE)) == ($past(NEXT_STATE) & $past(REGISTERED_MODE)))
    else $error("state clock did not load next state");

  // The serial pair settles two cycles after a shift edge
  a_out_far_end: assert property (@(posedge CLK) disable iff (RST)
    s_shift ##1 CE |=> SERIAL_PRELOAD_OUT_OE == ($past(preload_on) && !$past(top_bit)))
    else $error("serial out does not show chain top");

  // ****************************************************************
  // Refusal and far-end checks
  // ****************************************************************

  // Shift edge seen while the pin sits at normal level
  sequence s_shift_refused;
    CE && !preload_on && shift_now && !clock_now;
  endsequence

  // State clock edge seen while preload mode holds the chain
  sequence s_clock_refused;
    CE && preload_on && clock_now && !shift_now;
  endsequence

  // Top cell registered, so it alone drives the serial return
  sequence s_top_in_chain;
    CE && preload_on && REGISTERED_MODE[NUM_CELLS-1];
  endsequence

  a_shift_refused: assert property (@(posedge CLK) disable iff (RST)
    s_shift_refused |=> $stable(q))
    else $error("shift accepted without preload mode");

  a_clock_refused: assert property (@(posedge CLK) disable iff (RST)
    s_clock_refused |=> $stable(q))
    else $error("state clock accepted during preload mode");

  // Checks the far-end choice without the helper function
  a_top_cell_out: assert property (@(posedge CLK) disable iff (RST)
    s_top_in_chain |=> SERIAL_PRELOAD_OUT_OE == !$past(q[NUM_CELLS-1]))
    else $error("serial out does not follow top cell");

endmodule : register_preload_chain

// ### dv/preload_tester.sv
`timescale 1ns/1ps
// ****************************************************************
// Tester model on the preload pins, with the pull-up on the return
// ****************************************************************
module preload_tester (
  // Clock
  input  wire logic CLK,
  // Pins driven by the tester
  output logic      PIN,
  output logic      SCLK,
  output logic      SIN,
  // Open-drain serial return
  input  wire logic OUT,
  input  wire logic OE,
  output logic      LINE
);
  // Pull-up resistor wins whenever nobody pulls low
  assign LINE = (OE && !OUT) ? 1'b0 : 1'b1;

  // Idle pins at time zero; shift clock stands still outside frames
  initial begin
    PIN  = 1'b0;
    SCLK = 1'b0;
    SIN  = 1'b0;
  end

  // Shift n bits, top-cell bit first so bits[0] ends in the bottom cell
  task automatic load(input logic [7:0] bits, input int n, input logic hv);
    @(negedge CLK);
    PIN = hv;
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge CLK);
      SIN  = bits[i];
      SCLK = 1'b1;
      @(negedge CLK);
      SCLK = 1'b0;
      SIN  = ~SIN; // Data no longer valid once the edge is past
    end
    repeat (2) @(negedge CLK);
  endtask : load

  // Return the preload pin to normal level
  task automatic drop;
    @(negedge CLK);
    PIN = 1'b0;
  endtask : drop
endmodule : preload_tester

// ### dv/test_register_preload_chain.sv
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench of the preload chain
// ****************************************************************
module test_register_preload_chain;
  logic       clk, rst, ce, pin, sclk, sin, out, oe, line, stclk;
  logic [7:0] mode, nxt, q;
  int         n_mismatch = 0;
  int         n_checks   = 0;

  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  register_preload_chain uut (.CLK(clk), .RST(rst), .CE(ce), .PRELOAD_CONTROL_PIN(pin),
    .PRELOAD_SHIFT_CLOCK(sclk), .SERIAL_PRELOAD_IN(sin), .SERIAL_PRELOAD_OUT(out),
    .SERIAL_PRELOAD_OUT_OE(oe), .REGISTERED_MODE(mode), .STATE_CLOCK(stclk),
    .NEXT_STATE(nxt), .STATE_Q(q));
  preload_tester tester (.CLK(clk), .PIN(pin), .SCLK(sclk), .SIN(sin), .OUT(out),
    .OE(oe), .LINE(line));

  // Compare and count
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One normal clock rise, held for a sampled cycle each way
  task automatic state_pulse(input logic [7:0] v);
    @(negedge clk);
    nxt   = v;
    stclk = 1'b1;
    @(negedge clk);
    stclk = 1'b0;
    repeat (2) @(negedge clk);
  endtask : state_pulse

  // Full chain forced both ways, serial return shows the top cell
  task automatic t_full;
    mode = 8'hFF;
    tester.load(8'hC1, 8, 1'b1);
    check("state", q, 8'hC1);
    check("line", {7'h00, line}, 8'h01);
    tester.load(8'h3E, 8, 1'b1);
    check("state", q, 8'h3E);
    check("line", {7'h00, line}, 8'h00);
  endtask : t_full

  // Combinational cells skipped and left holding
  task automatic t_skip;
    mode = 8'h2C;
    tester.load(8'h06, 3, 1'b1);
    check("state", q, 8'h3A);
    check("line", {7'h00, line}, 8'h01);
  endtask : t_skip

  // Preloaded state advanced by one normal clock
  task automatic t_next;
    tester.drop();
    mode = 8'h0F;
    state_pulse(8'hC3);
    check("state", q, 8'h33);
    check("line", {7'h00, line}, 8'h01);
  endtask : t_next

  // Shifts ignored without the pin, normal clock ignored with it
  task automatic t_refuse;
    tester.load(8'hFF, 8, 1'b0);
    check("state", q, 8'h33);
    tester.load(8'h00, 0, 1'b1);
    state_pulse(8'h00);
    check("state", q, 8'h33);
    check("line", {7'h00, line}, 8'h00);
    tester.drop();
  endtask : t_refuse

  // Clock enable low freezes the chain and the serial return
  task automatic t_freeze;
    @(negedge clk);
    ce = 1'b0;
    tester.load(8'hFF, 4, 1'b1);
    check("state", q, 8'h33);
    check("line", {7'h00, line}, 8'h01);
    @(negedge clk);
    ce = 1'b1;
    tester.drop();
    check("state", q, 8'h33);
  endtask : t_freeze

  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // Watchdog against a hang
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end

  // Main sequence
  initial begin
    rst   = 1'b1;
    ce    = 1'b1;
    mode  = 8'h00;
    nxt   = 8'h00;
    stclk = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("reset", q, preload_pkg::STATE_RESET);
    t_full();
    t_skip();
    t_next();
    t_refuse();
    t_freeze();
    complete_run();
  end
endmodule : test_register_preload_chain
